// ---- verilog/dhi_defines.svh ----
`ifndef DHI_DEFINES_SVH
`define DHI_DEFINES_SVH
// Bus mode strap codes, written as {bit2, bit1, bit0}.
`define DHI_MODE_I2C 3'h2
`define DHI_MODE_EDIR 3'h4
`define DHI_MODE_STROBE 3'h6
`define DHI_MODE_SERIAL 3'h0
// Upper six bits of the two-wire slave address.
`define DHI_I2C_ADDR_HI 6'h1e
// Control byte field positions.
`define DHI_CTRL_CONT_BIT 7
`define DHI_CTRL_DC_BIT 6
// Link-side timing in host clock cycles.
`define DHI_LINK_HALF_CYCLES 4
`define DHI_RESET_IDLE 8'h00
`endif

// ---- verilog/dhi_pkg.sv ----
package dhi_pkg;
	typedef enum logic [2:0] {
		DHI_BUS_SERIAL = 3'h0,
		DHI_BUS_EDIR = 3'h1,
		DHI_BUS_STROBE = 3'h2,
		DHI_BUS_I2C = 3'h3,
		DHI_BUS_NONE = 3'h4
	} dhi_bus_type;
	typedef enum logic [2:0] {
		DHI_ST_IDLE = 3'h0,
		DHI_ST_SETUP = 3'h1,
		DHI_ST_STROBE = 3'h2,
		DHI_ST_HOLD = 3'h3,
		DHI_ST_SHIFT = 3'h4
	} dhi_host_state_type;
endpackage : dhi_pkg

// ---- verilog/dhi_link_if.sv ----
`timescale 1ns/1ps
// Pins between the host and the display device.
interface dhi_link_if;
	logic init_pin_low;
	logic chip_sel_n;
	logic data_cmd_sel;
	logic strobe_e;
	logic strobe_rw;
	logic [2:0] bus_mode_pins;
	logic osc_select;
	logic outside_timebase_in;
	logic [7:0] host_data_out;
	logic [7:0] host_data_oe_n;
	logic [7:0] dev_data_out;
	logic [7:0] dev_data_oe_n;
	logic frame_sync_out;
	modport device (
		input init_pin_low, chip_sel_n, data_cmd_sel, strobe_e, strobe_rw,
		input bus_mode_pins, osc_select, outside_timebase_in, host_data_out,
		input host_data_oe_n,
		output dev_data_out, dev_data_oe_n, frame_sync_out
	);
	modport host (
		output init_pin_low, chip_sel_n, data_cmd_sel, strobe_e, strobe_rw,
		output bus_mode_pins, osc_select, outside_timebase_in, host_data_out,
		output host_data_oe_n,
		input dev_data_out, dev_data_oe_n, frame_sync_out
	);
endinterface : dhi_link_if

// ---- verilog/dhi_sync.sv ----
`timescale 1ns/1ps
// Two-flop synchroniser for a group of pin levels.
module dhi_sync #(
	parameter int WIDTH = 8
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;
	// The first stage feeds only the second stage.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule : dhi_sync

// ---- verilog/dhi_device.sv ----
// Function
// - Low init pin resets device; host keeps high.
// - Serial and parallel access only while select is low.
// - Serial: data_cmd_sel high data, low command.
// - Two-wire mode: data_cmd_sel is address bit.
// - Enable-direction mode: cycle starts on enable rise.
// - Strobe mode: read starts on read low.
// - Direction high reads, low writes.
// - Strobe mode: write starts on write low.
// - Parallel modes use 8-bit two-way bus.
// - Serial: line 1 data, line 0 clock.
// - Two-wire: board joins lines 2,1; 0 clock.
// - Decode mode straps into four bus modes.
// - Oscillator select high runs internal oscillator.
// - Otherwise timebase comes from outside input.
// - Drive frame sync for tear-free writes.
// - 32 row outputs, two copies, off floats.
// - Column outputs float while display off.
// - Two-wire address low bit follows data_cmd_sel.
// - Control byte: continuation, data flag, zeros.
`timescale 1ns/1ps
`include "dhi_defines.svh"
module dhi_device #(
	parameter int ROWS = 32,
	parameter int COLS = 256,
	parameter int FRAME_TICKS = 64
) (
	input wire logic sys_clk,
	input wire logic rst,
	dhi_link_if.device link,
	input wire logic display_on,
	input wire logic [7:0] read_data,
	output logic [7:0] rx_byte,
	output logic rx_valid,
	output logic rx_is_data,
	output logic rd_strobe,
	output logic [ROWS-1:0] row_drive_a,
	output logic [ROWS-1:0] row_drive_b,
	output logic [ROWS-1:0] row_drive_oe_n,
	output logic [COLS-1:0] column_drive,
	output logic [COLS-1:0] column_drive_oe_n,
	output dhi_pkg::dhi_bus_type bus_mode
);
	import dhi_pkg::*;
	// ***********************************************************
	// Pin synchronisers.
	// ***********************************************************
	logic [15:0] pin_raw;
	logic [15:0] pin_s;
	logic [7:0] din;
	logic init_n, cs_n, dcs, pe, prw, osc_sel, tb_in;
	logic [2:0] straps;
	assign pin_raw = {link.init_pin_low, link.chip_sel_n, link.data_cmd_sel,
		link.strobe_e, link.strobe_rw, link.osc_select, link.outside_timebase_in,
		link.bus_mode_pins[0], link.host_data_out & ~link.host_data_oe_n};
	dhi_sync #(.WIDTH(16)) u_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.async_in(pin_raw),
		.sync_out(pin_s)
	);
	assign {init_n, cs_n, dcs, pe, prw, osc_sel, tb_in} = pin_s[15:9];
	assign din = pin_s[7:0];
	logic [2:0] straps_raw_s;
	dhi_sync #(.WIDTH(3)) u_strap_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.async_in(link.bus_mode_pins),
		.sync_out(straps_raw_s)
	);
	assign straps = straps_raw_s;
	// Held in reset while the init pin is low.
	logic run;
	assign run = init_n;

	// Strap decoding.
	function automatic dhi_bus_type decode_mode(input logic [2:0] s);
		case (s)
			`DHI_MODE_I2C: decode_mode = DHI_BUS_I2C;
			`DHI_MODE_EDIR: decode_mode = DHI_BUS_EDIR;
			`DHI_MODE_STROBE: decode_mode = DHI_BUS_STROBE;
			`DHI_MODE_SERIAL: decode_mode = DHI_BUS_SERIAL;
			default: decode_mode = DHI_BUS_NONE;
		endcase
	endfunction : decode_mode

	// Mode is captured while in init, after the clock runs.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bus_mode <= DHI_BUS_NONE;
		end else if (!run) begin
			bus_mode <= decode_mode(straps);
		end
	end

	// ***********************************************************
	// Edge history.
	// ***********************************************************
	logic pe_d, prw_d, sclk_d, sda_d, tb_d;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pe_d <= 1'b0;
			prw_d <= 1'b1;
			sclk_d <= 1'b0;
			sda_d <= 1'b1;
			tb_d <= 1'b0;
		end else begin
			pe_d <= pe;
			prw_d <= prw;
			sclk_d <= din[0];
			sda_d <= din[1];
			tb_d <= tb_in;
		end
	end
	logic sel;
	assign sel = run && !cs_n;
	logic e_rise, rd_fall, wr_fall, sclk_rise, sda_fall, sda_rise;
	assign e_rise = pe && !pe_d;
	assign rd_fall = !pe && pe_d;
	assign wr_fall = !prw && prw_d;
	assign sclk_rise = din[0] && !sclk_d;
	assign sda_fall = !din[1] && sda_d && din[0];
	assign sda_rise = din[1] && !sda_d && din[0];

	// ***********************************************************
	// Receive paths.
	// ***********************************************************
	logic [2:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic i2c_phase_reg;
	logic i2c_addr_ok_reg;
	logic i2c_ack_reg;
	logic i2c_ctrl_seen_reg;
	logic i2c_dc_reg;
	logic i2c_cont_reg;
	logic [7:0] shifted;
	assign shifted = {shift_reg[6:0], din[1]};
	logic two_wire;
	assign two_wire = (bus_mode == DHI_BUS_I2C);

	// One process handles every bus mode since only one is strapped.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rx_byte <= 8'h00;
			rx_valid <= 1'b0;
			rx_is_data <= 1'b0;
			rd_strobe <= 1'b0;
			bit_cnt_reg <= 3'h0;
			shift_reg <= 8'h00;
			i2c_phase_reg <= 1'b0;
			i2c_addr_ok_reg <= 1'b0;
			i2c_ack_reg <= 1'b0;
			i2c_ctrl_seen_reg <= 1'b0;
			i2c_dc_reg <= 1'b0;
			i2c_cont_reg <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			rd_strobe <= 1'b0;
			if (!run) begin
				bit_cnt_reg <= 3'h0;
				i2c_phase_reg <= 1'b0;
				i2c_addr_ok_reg <= 1'b0;
				i2c_ack_reg <= 1'b0;
			end else if (two_wire) begin
				// Two-wire receive; select pin is ignored in this mode.
				if (sda_fall) begin
					bit_cnt_reg <= 3'h0;
					i2c_phase_reg <= 1'b0;
					i2c_addr_ok_reg <= 1'b1;
					i2c_ctrl_seen_reg <= 1'b0;
					i2c_cont_reg <= 1'b1;
				end else if (sda_rise) begin
					i2c_addr_ok_reg <= 1'b0;
				end else if (!din[0] && sclk_d && i2c_ack_reg) begin
					i2c_ack_reg <= 1'b0;
				end else if (sclk_rise && i2c_addr_ok_reg && !i2c_ack_reg) begin
					shift_reg <= shifted;
					bit_cnt_reg <= bit_cnt_reg + 3'h1;
					if (bit_cnt_reg == 3'h7) begin
						i2c_ack_reg <= 1'b1;
						if (!i2c_phase_reg) begin
							// Address low bit follows data_cmd_sel; write only.
							i2c_addr_ok_reg <= (shifted == {`DHI_I2C_ADDR_HI, dcs, 1'b0});
							i2c_ack_reg <= (shifted == {`DHI_I2C_ADDR_HI, dcs, 1'b0});
							i2c_phase_reg <= 1'b1;
						end else if (!i2c_ctrl_seen_reg || i2c_cont_reg) begin
							// Control byte carries continuation and data flags.
							i2c_ctrl_seen_reg <= 1'b1;
							i2c_cont_reg <= shifted[`DHI_CTRL_CONT_BIT];
							i2c_dc_reg <= shifted[`DHI_CTRL_DC_BIT];
						end else begin
							rx_byte <= shifted;
							rx_is_data <= i2c_dc_reg;
							rx_valid <= 1'b1;
						end
					end
				end
			end else if (!sel) begin
				bit_cnt_reg <= 3'h0;
			end else if (bus_mode == DHI_BUS_SERIAL) begin
				if (sclk_rise) begin
					shift_reg <= shifted;
					bit_cnt_reg <= bit_cnt_reg + 3'h1;
					if (bit_cnt_reg == 3'h7) begin
						rx_byte <= shifted;
						rx_is_data <= dcs;
						rx_valid <= 1'b1;
					end
				end
			end else if (bus_mode == DHI_BUS_EDIR && e_rise) begin
				// Direction picks read or write.
				if (prw) begin
					rd_strobe <= 1'b1;
				end else begin
					rx_byte <= din;
					rx_is_data <= dcs;
					rx_valid <= 1'b1;
				end
			end else if (bus_mode == DHI_BUS_STROBE) begin
				if (rd_fall) begin
					rd_strobe <= 1'b1;
				end else if (wr_fall) begin
					rx_byte <= din;
					rx_is_data <= dcs;
					rx_valid <= 1'b1;
				end
			end
		end
	end

	// ***********************************************************
	// Read-back drive and two-wire acknowledge.
	// ***********************************************************
	logic rd_active;
	assign rd_active = sel && ((bus_mode == DHI_BUS_EDIR && prw && pe) ||
		(bus_mode == DHI_BUS_STROBE && !pe));
	// Data lines float unless a read is in progress or an ack is owed.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			link.dev_data_out <= 8'h00;
			link.dev_data_oe_n <= 8'hff;
		end else if (run && two_wire && i2c_ack_reg && !din[0]) begin
			link.dev_data_out <= 8'h00;
			link.dev_data_oe_n <= 8'hfb;
		end else if (run && two_wire) begin
			link.dev_data_out <= 8'h00;
			link.dev_data_oe_n <= 8'hff;
		end else if (rd_active) begin
			link.dev_data_out <= read_data;
			link.dev_data_oe_n <= 8'h00;
		end else begin
			link.dev_data_out <= 8'h00;
			link.dev_data_oe_n <= 8'hff;
		end
	end

	// ***********************************************************
	// Timebase, frame sync and panel drivers.
	// ***********************************************************
	logic tick;
	// Internal oscillator ticks each cycle; otherwise count outside edges.
	assign tick = osc_sel ? 1'b1 : (tb_in && !tb_d);
	logic [$clog2(FRAME_TICKS)-1:0] tick_cnt_reg;
	logic [$clog2(ROWS)-1:0] row_idx_reg;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tick_cnt_reg <= '0;
			row_idx_reg <= '0;
			link.frame_sync_out <= 1'b0;
		end else if (!run) begin
			tick_cnt_reg <= '0;
			row_idx_reg <= '0;
			link.frame_sync_out <= 1'b0;
		end else if (tick) begin
			tick_cnt_reg <= tick_cnt_reg + 1'b1;
			if (&tick_cnt_reg) begin
				row_idx_reg <= row_idx_reg + 1'b1;
				// Pulses high over the last row for safe RAM writes.
				link.frame_sync_out <= (row_idx_reg == $clog2(ROWS)'(ROWS - 2));
			end
		end
	end
	// Both row copies match; all panel outputs float when off.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			row_drive_a <= '0;
			row_drive_b <= '0;
			row_drive_oe_n <= '1;
			column_drive <= '0;
			column_drive_oe_n <= '1;
		end else begin
			row_drive_a <= ROWS'(1) << row_idx_reg;
			row_drive_b <= ROWS'(1) << row_idx_reg;
			row_drive_oe_n <= {ROWS{!(display_on && run)}};
			column_drive <= {COLS{display_on}};
			column_drive_oe_n <= {COLS{!(display_on && run)}};
		end
	end
endmodule : dhi_device

// ---- verilog/dhi_host.sv ----
`timescale 1ns/1ps
`include "dhi_defines.svh"
module dhi_host (
	input wire logic sys_clk,
	input wire logic rst,
	dhi_link_if.host link,
	input wire logic [2:0] mode_strap,
	input wire logic use_internal_osc,
	input wire logic hold_init,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic req_is_data,
	input wire logic [7:0] req_byte,
	output logic req_ready,
	output logic [7:0] rsp_byte,
	output logic rsp_valid
);
	import dhi_pkg::*;
	// ***********************************************************
	// Static pins.
	// ***********************************************************
	logic [2:0] half_reg;
	logic tb_reg;
	// Straps and init level come from registers; timebase is divided.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			link.init_pin_low <= 1'b0;
			link.bus_mode_pins <= `DHI_MODE_SERIAL;
			link.osc_select <= 1'b1;
			half_reg <= 3'h0;
			tb_reg <= 1'b0;
		end else begin
			link.init_pin_low <= !hold_init;
			link.bus_mode_pins <= mode_strap;
			link.osc_select <= use_internal_osc;
			half_reg <= (half_reg == 3'(`DHI_LINK_HALF_CYCLES - 1)) ? 3'h0 : half_reg + 3'h1;
			// The timebase is grounded at once when the internal oscillator is chosen.
			if (use_internal_osc) begin
				tb_reg <= 1'b0;
			end else if (half_reg == 3'(`DHI_LINK_HALF_CYCLES - 1)) begin
				tb_reg <= !tb_reg;
			end
		end
	end
	assign link.outside_timebase_in = tb_reg;

	// ***********************************************************
	// Transfer engine; parallel modes only plus serial write.
	// ***********************************************************
	dhi_host_state_type st_reg;
	logic [3:0] cnt_reg;
	logic [7:0] sh_reg;
	logic wr_reg;
	logic [7:0] rd_s1, rd_s2;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rd_s1 <= 8'h00;
			rd_s2 <= 8'h00;
		end else begin
			rd_s1 <= link.dev_data_out & ~link.dev_data_oe_n;
			rd_s2 <= rd_s1;
		end
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_reg <= DHI_ST_IDLE;
			cnt_reg <= 4'h0;
			sh_reg <= 8'h00;
			wr_reg <= 1'b0;
			req_ready <= 1'b0;
			rsp_byte <= 8'h00;
			rsp_valid <= 1'b0;
			link.chip_sel_n <= 1'b1;
			link.data_cmd_sel <= 1'b0;
			link.strobe_e <= 1'b0;
			link.strobe_rw <= 1'b1;
			link.host_data_out <= 8'h00;
			link.host_data_oe_n <= 8'hff;
		end else begin
			rsp_valid <= 1'b0;
			req_ready <= 1'b0;
			case (st_reg)
				DHI_ST_IDLE: begin
					link.chip_sel_n <= 1'b1;
					link.host_data_oe_n <= 8'hff;
					link.strobe_e <= (mode_strap == `DHI_MODE_STROBE);
					link.strobe_rw <= 1'b1;
					if (req_valid && !hold_init) begin
						req_ready <= 1'b1;
						wr_reg <= req_write || (mode_strap == `DHI_MODE_SERIAL);
						sh_reg <= req_byte;
						link.data_cmd_sel <= req_is_data;
						link.chip_sel_n <= 1'b0;
						cnt_reg <= 4'h0;
						st_reg <= DHI_ST_SETUP;
					end
				end
				DHI_ST_SETUP: begin
					if (mode_strap == `DHI_MODE_SERIAL) begin
						link.host_data_oe_n <= 8'hfc;
						st_reg <= DHI_ST_SHIFT;
					end else begin
						link.host_data_out <= sh_reg;
						link.host_data_oe_n <= wr_reg ? 8'h00 : 8'hff;
						if (mode_strap == `DHI_MODE_EDIR) begin
							link.strobe_rw <= !wr_reg;
							link.strobe_e <= 1'b1;
						end else if (wr_reg) begin
							link.strobe_rw <= 1'b0;
						end else begin
							link.strobe_e <= 1'b0;
						end
						st_reg <= DHI_ST_STROBE;
					end
				end
				DHI_ST_STROBE: begin
					cnt_reg <= cnt_reg + 4'h1;
					if (cnt_reg == 4'h7) begin
						rsp_byte <= rd_s2;
						rsp_valid <= !wr_reg;
						link.strobe_e <= (mode_strap == `DHI_MODE_STROBE);
						link.strobe_rw <= 1'b1;
						st_reg <= DHI_ST_HOLD;
					end
				end
				DHI_ST_SHIFT: begin
					cnt_reg <= cnt_reg + 4'h1;
					// Clock low with data, then high; sixteen counts give eight bits.
					link.host_data_out <= {6'h00, sh_reg[7], cnt_reg[0]};
					if (cnt_reg[0]) begin
						sh_reg <= {sh_reg[6:0], 1'b0};
					end
					if (cnt_reg == 4'hf) begin
						st_reg <= DHI_ST_HOLD;
					end
				end
				DHI_ST_HOLD: begin
					link.host_data_out <= 8'h00;
					st_reg <= DHI_ST_IDLE;
				end
				default: st_reg <= DHI_ST_IDLE;
			endcase
		end
	end
endmodule : dhi_host

// ---- tb/dhi_link_properties.sv ----
`timescale 1ns/1ps
`include "dhi_defines.svh"
// Pin-level checks on the link between the host and the device.
module dhi_link_properties (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic init_pin_low,
	input wire logic chip_sel_n,
	input wire logic strobe_e,
	input wire logic strobe_rw,
	input wire logic [2:0] bus_mode_pins,
	input wire logic osc_select,
	input wire logic outside_timebase_in,
	input wire logic [7:0] host_data_out,
	input wire logic [7:0] host_data_oe_n,
	input wire logic [7:0] dev_data_oe_n,
	input wire logic frame_sync_out
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	// ****************************************
	// Properties
	// ****************************************
	property p_desel_float;
		(chip_sel_n && bus_mode_pins != `DHI_MODE_I2C) [*4] |-> dev_data_oe_n == 8'hff;
	endproperty
	a_desel_float: assert property (p_desel_float) else $error("data driven while idle");
	property p_init_idle;
		!init_pin_low |-> chip_sel_n;
	endproperty
	a_init_idle: assert property (p_init_idle) else $error("select during init");
	property p_strap_static;
		init_pin_low && $past(init_pin_low) |-> $stable(bus_mode_pins) && $stable(osc_select);
	endproperty
	a_strap_static: assert property (p_strap_static) else $error("strap moved");
	property p_osc_tie;
		osc_select [*3] |-> !outside_timebase_in;
	endproperty
	a_osc_tie: assert property (p_osc_tie) else $error("timebase not grounded");
	property p_timebase_runs;
		(!osc_select && init_pin_low) [*2] |-> ##[1:9] $changed(outside_timebase_in);
	endproperty
	a_timebase_runs: assert property (p_timebase_runs) else $error("timebase stuck");
	property p_edir_sel;
		init_pin_low && bus_mode_pins == `DHI_MODE_EDIR && $rose(strobe_e) |-> !chip_sel_n;
	endproperty
	a_edir_sel: assert property (p_edir_sel) else $error("enable without select");
	property p_rd_sel;
		init_pin_low && bus_mode_pins == `DHI_MODE_STROBE && $fell(strobe_e) |-> !chip_sel_n;
	endproperty
	a_rd_sel: assert property (p_rd_sel) else $error("read strobe without select");
	property p_wr_hold;
		init_pin_low && bus_mode_pins == `DHI_MODE_STROBE && $fell(strobe_rw)
			|=> (!strobe_rw && !chip_sel_n && $stable(host_data_out)) [*7];
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write cycle cut short");
	property p_rd_drive;
		(init_pin_low && bus_mode_pins == `DHI_MODE_EDIR && strobe_e && strobe_rw && !chip_sel_n)
			[*6] |-> dev_data_oe_n == 8'h00;
	endproperty
	a_rd_drive: assert property (p_rd_drive) else $error("read data not driven");
	property p_no_clash;
		(host_data_oe_n != 8'hff) [*4] |-> dev_data_oe_n == 8'hff;
	endproperty
	a_no_clash: assert property (p_no_clash) else $error("both ends drive data");
	// Main scenarios reached.
	c_edir: cover property (bus_mode_pins == `DHI_MODE_EDIR && $rose(strobe_e));
	c_strobe_wr: cover property (bus_mode_pins == `DHI_MODE_STROBE && $fell(strobe_rw));
	c_frame: cover property ($rose(frame_sync_out));
endmodule : dhi_link_properties

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`include "dhi_defines.svh"
module testbench;
	import dhi_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] mode_strap = `DHI_MODE_SERIAL;
	logic use_internal_osc = 1'b0;
	logic hold_init = 1'b0;
	logic req_valid = 1'b0, req_write = 1'b0, req_is_data = 1'b0;
	logic [7:0] req_byte = 8'h00, read_data = 8'ha5;
	logic display_on = 1'b0;
	logic req_ready, rsp_valid, rx_valid, rx_is_data, rd_strobe, rx_valid_b, got_dc;
	logic [7:0] rsp_byte, rx_byte, rx_byte_b, got_byte, got_rsp, got_b;
	logic [31:0] row_drive_a, row_drive_b, row_drive_oe_n;
	logic [255:0] column_drive, column_drive_oe_n;
	dhi_bus_type bus_mode;
	int fails = 0, n_checks = 0, n_rx = 0, n_rsp = 0, n_rd = 0, n_rx_b = 0;
	logic [2:0] modes [4] = '{`DHI_MODE_SERIAL, `DHI_MODE_EDIR, `DHI_MODE_STROBE, `DHI_MODE_I2C};
	dhi_bus_type kinds [4] = '{DHI_BUS_SERIAL, DHI_BUS_EDIR, DHI_BUS_STROBE, DHI_BUS_I2C};
	dhi_link_if link ();
	dhi_link_if link_b ();
	dhi_host dhi_host_inst (.sys_clk(sys_clk), .rst(rst), .link(link), .mode_strap(mode_strap),
		.use_internal_osc(use_internal_osc), .hold_init(hold_init), .req_valid(req_valid),
		.req_write(req_write), .req_is_data(req_is_data), .req_byte(req_byte),
		.req_ready(req_ready), .rsp_byte(rsp_byte), .rsp_valid(rsp_valid));
	dhi_device #(.FRAME_TICKS(4)) dhi_device_inst (.sys_clk(sys_clk), .rst(rst), .link(link),
		.display_on(display_on), .read_data(read_data), .rx_byte(rx_byte), .rx_valid(rx_valid),
		.rx_is_data(rx_is_data), .rd_strobe(rd_strobe), .row_drive_a(row_drive_a),
		.row_drive_b(row_drive_b), .row_drive_oe_n(row_drive_oe_n), .column_drive(column_drive),
		.column_drive_oe_n(column_drive_oe_n), .bus_mode(bus_mode));
	// Second device whose pins the bench drives, to break the host's side on purpose.
	dhi_device #(.FRAME_TICKS(4)) dhi_device_inst_b (.sys_clk(sys_clk), .rst(rst),
		.link(link_b), .display_on(1'b0), .read_data(8'h00), .rx_byte(rx_byte_b),
		.rx_valid(rx_valid_b), .rx_is_data(), .rd_strobe(), .row_drive_a(), .row_drive_b(),
		.row_drive_oe_n(), .column_drive(), .column_drive_oe_n(), .bus_mode());
	dhi_link_properties dhi_link_properties_inst (.sys_clk(sys_clk), .rst(rst),
		.init_pin_low(link.init_pin_low), .chip_sel_n(link.chip_sel_n),
		.strobe_e(link.strobe_e), .strobe_rw(link.strobe_rw),
		.bus_mode_pins(link.bus_mode_pins), .osc_select(link.osc_select),
		.outside_timebase_in(link.outside_timebase_in), .host_data_out(link.host_data_out),
		.host_data_oe_n(link.host_data_oe_n), .dev_data_oe_n(link.dev_data_oe_n),
		.frame_sync_out(link.frame_sync_out));
	// Clock.
	always #20 sys_clk = ~sys_clk;
	// Capture every received byte, read answer and read start.
	always @(posedge sys_clk) begin
		if (rx_valid === 1'b1) begin
			got_byte <= rx_byte;
			got_dc <= rx_is_data;
			n_rx <= n_rx + 1;
		end
		if (rsp_valid === 1'b1) begin
			got_rsp <= rsp_byte;
			n_rsp <= n_rsp + 1;
		end
		if (rd_strobe === 1'b1) begin
			n_rd <= n_rd + 1;
		end
		if (rx_valid_b === 1'b1) begin
			got_b <= rx_byte_b;
			n_rx_b <= n_rx_b + 1;
		end
	end
	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t %s: saw %h expected %h", $time, what, seen, exp);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : cyc
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : wrap_up
	// Waits a bounded time for a counter to move away from its start value.
	task automatic wait_for(ref int cnt, input int start);
		int k;
		k = 0;
		while (cnt == start && k < 300) begin
			cyc(1);
			k++;
		end
		check(32'(cnt - start), 32'h1, "event count");
	endtask : wait_for
	// Re-initialises the device with new strap levels while the init pin is held low.
	task automatic set_mode(input logic [2:0] m, input logic osc);
		hold_init = 1'b1;
		cyc(6);
		mode_strap = m;
		use_internal_osc = osc;
		cyc(10);
		hold_init = 1'b0;
		cyc(12);
	endtask : set_mode
	// One transfer through the host; writes are checked at the device, reads at the host.
	task automatic request(input logic wr, input logic dc, input logic [7:0] b);
		int k;
		int rx0;
		int rsp0;
		int rd0;
		rx0 = n_rx;
		rsp0 = n_rsp;
		rd0 = n_rd;
		req_valid = 1'b1;
		req_write = wr;
		req_is_data = dc;
		req_byte = b;
		k = 0;
		do begin
			cyc(1);
			k++;
		end while (req_ready !== 1'b1 && k < 20);
		req_valid = 1'b0;
		if (wr) begin
			wait_for(n_rx, rx0);
			check(32'(got_byte), 32'(b), "byte");
			check(32'(got_dc), 32'(dc), "data flag");
		end else begin
			wait_for(n_rsp, rsp0);
			check(32'(got_rsp), 32'(read_data), "read byte");
			check(32'(n_rd - rd0), 32'h1, "read starts");
		end
		cyc(4);
	endtask : request
	// Bench-driven write strobe on the second link.
	task automatic pulse_b(input logic sel, input logic init_high, input int exp);
		int r0;
		r0 = n_rx_b;
		link_b.init_pin_low = init_high;
		link_b.chip_sel_n = ~sel;
		cyc(6);
		link_b.strobe_rw = 1'b0;
		cyc(9);
		link_b.strobe_rw = 1'b1;
		cyc(8);
		link_b.chip_sel_n = 1'b1;
		check(32'(n_rx_b - r0), 32'(exp), "bytes taken");
	endtask : pulse_b
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		link_b.init_pin_low = 1'b0;
		link_b.chip_sel_n = 1'b1;
		link_b.data_cmd_sel = 1'b1;
		link_b.strobe_e = 1'b1;
		link_b.strobe_rw = 1'b1;
		link_b.bus_mode_pins = `DHI_MODE_STROBE;
		link_b.osc_select = 1'b1;
		link_b.outside_timebase_in = 1'b0;
		link_b.host_data_out = 8'h3c;
		link_b.host_data_oe_n = 8'h00;
		cyc(16);
		rst = 1'b0;
		cyc(4);
		for (int i = 0; i < 4; i++) begin
			read_data = 8'(8'ha5 + i);
			set_mode(modes[i], i[0]);
			check(32'(bus_mode), 32'(kinds[i]), "bus mode");
			if (i < 3) begin
				request(1'b1, 1'b0, 8'(8'h81 + i));
				request(1'b1, 1'b1, 8'(8'h7e - i));
			end
			if (i == 1 || i == 2) begin
				request(1'b0, 1'b1, 8'h00);
			end
		end
		display_on = 1'b0;
		cyc(6);
		check(32'(&row_drive_oe_n), 32'h1, "rows float");
		check(32'(&column_drive_oe_n), 32'h1, "columns float");
		display_on = 1'b1;
		cyc(6);
		check(32'(|row_drive_oe_n), 32'h0, "rows driven");
		check(32'(|column_drive_oe_n), 32'h0, "columns driven");
		check(32'(row_drive_a === row_drive_b), 32'h1, "row copies");
		for (int j = 0; j < 2; j++) begin
			set_mode(`DHI_MODE_STROBE, j[0]);
			for (int k = 0; k < 6000 && link.frame_sync_out !== 1'b1; k++) begin
				cyc(1);
			end
			check(32'(link.frame_sync_out), 32'h1, "frame sync");
		end
		link_b.init_pin_low = 1'b1;
		cyc(8);
		pulse_b(1'b0, 1'b1, 0);
		link_b.strobe_e = 1'b0;
		cyc(8);
		check(32'(link_b.dev_data_oe_n), 32'h0000_00ff, "idle data floats");
		link_b.strobe_e = 1'b1;
		pulse_b(1'b1, 1'b0, 0);
		pulse_b(1'b1, 1'b1, 1);
		check(32'(got_b), 32'h0000_003c, "selected write");
		wrap_up();
	end
	// Cuts a hung run short.
	initial begin
		repeat (40000) @(posedge sys_clk);
		fails++;
		$display("[ERR] %0t run did not finish", $time);
		wrap_up();
	end
endmodule : testbench
